// [verilog/lsr_regs.svh]
// Register offsets, field positions, reset values and reaction codes of the limit switch reaction block.
// Assumes a 16-bit word address on the plain register port.
`ifndef LSR_REGS_SVH
`define LSR_REGS_SVH

`define LSR_ADDR_W            16
`define LSR_OFF_REACTION      16'h3701
`define LSR_OFF_HWINFO_CNT    16'h4100
`define LSR_OFF_EEPROM_SIZE   16'h4101
`define LSR_OFF_HWCFG_CNT     16'h4102
`define LSR_OFF_HWCFG_WORD    16'h4103
`define LSR_OFF_IRQ_STATUS    16'h4110
`define LSR_OFF_IRQ_CLEAR     16'h4111
`define LSR_OFF_IRQ_ENABLE    16'h4112
`define LSR_OFF_LIMIT_POS     16'h4120
`define LSR_OFF_REACT_STATE   16'h4121

`define LSR_RST_REACTION      16'hffff
`define LSR_RST_HWCFG_WORD    32'h0000_0000
`define LSR_ENTRY_COUNT       8'h01

`define LSR_STATUSWORD_WARN_BIT 7

`define LSR_IRQ_W             3
`define LSR_IRQ_LIMIT_EVT     0
`define LSR_IRQ_REACT_DONE    1
`define LSR_IRQ_POS_CAPTURED  2

`define LSR_CODE_DISCARD      16'hfffe
`define LSR_CODE_RECORD       16'hffff
`define LSR_CODE_POWER_OFF    16'h0000
`define LSR_CODE_SLOW_SOD     16'h0001
`define LSR_CODE_QUICK_SOD    16'h0002
`define LSR_CODE_SLOW_QSA     16'h0005
`define LSR_CODE_QUICK_QSA    16'h0006

`endif

// [verilog/lsr_pkg.sv]
// Types shared by the limit switch reaction block.
// Assumes lsr_regs.svh carries the numeric constants.
package lsr_pkg;

  typedef enum logic [2:0] {
    LSR_ACT_NONE,
    LSR_ACT_RECORD,
    LSR_ACT_DISCARD,
    LSR_ACT_POWER_OFF,
    LSR_ACT_BRAKE
  } lsr_action_t;

  typedef enum logic [1:0] {
    LSR_ST_IDLE,
    LSR_ST_BRAKE,
    LSR_ST_DONE
  } lsr_state_t;

endpackage : lsr_pkg

// [verilog/lsr_top.sv]
// Limit switch overrun reaction, hardware information and hardware configuration registers.
// Assumes limit switch pins are asynchronous, while position, ramp done and the register port share clk.
`timescale 1ns/1ns
`include "lsr_regs.svh"

module lsr_top #(
  parameter logic [31:0] EEPROM_SIZE_BYTES = 32'h0000_0000,
  parameter int          POS_W             = 32
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [`LSR_ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_we,
  input  wire logic                     reg_re,
  output logic      [31:0]              reg_rdata,
  input  wire logic                     limit_pos_pin,
  input  wire logic                     limit_neg_pin,
  input  wire logic [POS_W-1:0]         actual_position,
  input  wire logic                     ramp_done,
  output logic                          statusword_warning,
  output logic                          power_stage_off,
  output logic                          brake_slow,
  output logic                          brake_quick,
  output logic                          req_switch_on_disabled,
  output logic                          req_quick_stop_active,
  output logic [POS_W-1:0]              limit_position,
  output logic                          limit_position_valid,
  output logic                          irq
);

  // Decode of a stored reaction code into the action it asks for
  function automatic lsr_pkg::lsr_action_t decode_code(input logic [15:0] code);
    lsr_pkg::lsr_action_t act;
    case (code)
      `LSR_CODE_DISCARD:   act = lsr_pkg::LSR_ACT_DISCARD;
      `LSR_CODE_RECORD:    act = lsr_pkg::LSR_ACT_RECORD;
      `LSR_CODE_POWER_OFF: act = lsr_pkg::LSR_ACT_POWER_OFF;
      `LSR_CODE_SLOW_SOD,
      `LSR_CODE_QUICK_SOD,
      `LSR_CODE_SLOW_QSA,
      `LSR_CODE_QUICK_QSA: act = lsr_pkg::LSR_ACT_BRAKE;
      default:             act = lsr_pkg::LSR_ACT_RECORD;
    endcase
    return act;
  endfunction : decode_code

  // Quick-stop ramp codes
  function automatic logic is_quick(input logic [15:0] code);
    return (code == `LSR_CODE_QUICK_SOD) || (code == `LSR_CODE_QUICK_QSA);
  endfunction : is_quick

  // Codes that end in quick-stop-active with the power stage kept on
  function automatic logic ends_in_qsa(input logic [15:0] code);
    return (code == `LSR_CODE_SLOW_QSA) || (code == `LSR_CODE_QUICK_QSA);
  endfunction : ends_in_qsa

  // Limit switch synchronisers and edge detection
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] sync1_d;
  logic [1:0] sync2_d;
  logic [1:0] sync3_d;
  logic       overrun;

  always_comb begin
    sync1_d = {limit_neg_pin, limit_pos_pin};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  // A switch being reached is a rising edge on either synchronised input
  assign overrun = |(sync2_q & ~sync3_q);

  // Register port decode
  logic wr_reaction;
  logic wr_hwcfg;
  logic wr_clear;
  logic wr_enable;

  assign wr_reaction = reg_we && (reg_addr == `LSR_OFF_REACTION);
  assign wr_hwcfg    = reg_we && (reg_addr == `LSR_OFF_HWCFG_WORD);
  assign wr_clear    = reg_we && (reg_addr == `LSR_OFF_IRQ_CLEAR);
  assign wr_enable   = reg_we && (reg_addr == `LSR_OFF_IRQ_ENABLE);

  // Software registers
  logic [15:0]            reaction_q;
  logic [15:0]            reaction_d;
  logic [31:0]            hwcfg_q;
  logic [31:0]            hwcfg_d;
  logic [`LSR_IRQ_W-1:0]  irq_en_q;
  logic [`LSR_IRQ_W-1:0]  irq_en_d;

  always_comb begin
    reaction_d = reaction_q;
    hwcfg_d    = hwcfg_q;
    irq_en_d   = irq_en_q;
    if (wr_reaction) begin
      reaction_d = reg_wdata[15:0];
    end
    if (wr_hwcfg) begin
      hwcfg_d = reg_wdata;
    end
    if (wr_enable) begin
      irq_en_d = reg_wdata[`LSR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reaction_q <= `LSR_RST_REACTION;
      hwcfg_q    <= `LSR_RST_HWCFG_WORD;
      irq_en_q   <= '0;
    end else begin
      reaction_q <= reaction_d;
      hwcfg_q    <= hwcfg_d;
      irq_en_q   <= irq_en_d;
    end
  end

  // Reaction sequencer
  lsr_pkg::lsr_state_t  state_q;
  lsr_pkg::lsr_state_t  state_d;
  lsr_pkg::lsr_action_t action;
  logic [15:0]          latched_code_q;
  logic [15:0]          latched_code_d;
  logic [POS_W-1:0]     pos_q;
  logic [POS_W-1:0]     pos_d;
  logic                 pos_valid_q;
  logic                 pos_valid_d;
  logic                 power_off_q;
  logic                 power_off_d;
  logic                 req_sod_q;
  logic                 req_sod_d;
  logic                 req_qsa_q;
  logic                 req_qsa_d;
  logic                 captured;
  logic                 react_done;

  assign action = decode_code(reaction_q);

  always_comb begin
    state_d        = state_q;
    latched_code_d = latched_code_q;
    pos_d          = pos_q;
    pos_valid_d    = pos_valid_q;
    power_off_d    = 1'b0;
    req_sod_d      = 1'b0;
    req_qsa_d      = 1'b0;
    captured       = 1'b0;
    react_done     = 1'b0;
    case (state_q)
      lsr_pkg::LSR_ST_IDLE: begin
        if (overrun) begin
          case (action)
            lsr_pkg::LSR_ACT_DISCARD: begin
              pos_valid_d = 1'b0;
            end
            lsr_pkg::LSR_ACT_RECORD: begin
              pos_d       = actual_position;
              pos_valid_d = 1'b1;
              captured    = 1'b1;
            end
            lsr_pkg::LSR_ACT_POWER_OFF: begin
              power_off_d = 1'b1;
              req_sod_d   = 1'b1;
              react_done  = 1'b1;
            end
            lsr_pkg::LSR_ACT_BRAKE: begin
              latched_code_d = reaction_q;
              state_d        = lsr_pkg::LSR_ST_BRAKE;
            end
            default: begin
              state_d = lsr_pkg::LSR_ST_IDLE;
            end
          endcase
        end
      end
      lsr_pkg::LSR_ST_BRAKE: begin
        // Further overruns only raise the warning while a ramp runs
        if (ramp_done) begin
          state_d = lsr_pkg::LSR_ST_DONE;
        end
      end
      lsr_pkg::LSR_ST_DONE: begin
        req_qsa_d  = ends_in_qsa(latched_code_q);
        req_sod_d  = !ends_in_qsa(latched_code_q);
        react_done = 1'b1;
        state_d    = lsr_pkg::LSR_ST_IDLE;
      end
      default: begin
        state_d = lsr_pkg::LSR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q        <= lsr_pkg::LSR_ST_IDLE;
      latched_code_q <= `LSR_RST_REACTION;
      pos_q          <= '0;
      pos_valid_q    <= 1'b0;
      power_off_q    <= 1'b0;
      req_sod_q      <= 1'b0;
      req_qsa_q      <= 1'b0;
    end else begin
      state_q        <= state_d;
      latched_code_q <= latched_code_d;
      pos_q          <= pos_d;
      pos_valid_q    <= pos_valid_d;
      power_off_q    <= power_off_d;
      req_sod_q      <= req_sod_d;
      req_qsa_q      <= req_qsa_d;
    end
  end

  // Ramp selection is held for the whole braking phase
  assign brake_slow             = (state_q == lsr_pkg::LSR_ST_BRAKE) && !is_quick(latched_code_q);
  assign brake_quick            = (state_q == lsr_pkg::LSR_ST_BRAKE) && is_quick(latched_code_q);
  assign power_stage_off        = power_off_q;
  assign req_switch_on_disabled = req_sod_q;
  assign req_quick_stop_active  = req_qsa_q;
  assign limit_position         = pos_q;
  assign limit_position_valid   = pos_valid_q;

  // Sticky event status and interrupt
  logic [`LSR_IRQ_W-1:0] irq_st_q;
  logic [`LSR_IRQ_W-1:0] irq_st_d;
  logic [`LSR_IRQ_W-1:0] irq_set;

  always_comb begin
    irq_set                         = '0;
    irq_set[`LSR_IRQ_LIMIT_EVT]     = overrun;
    irq_set[`LSR_IRQ_REACT_DONE]    = react_done;
    irq_set[`LSR_IRQ_POS_CAPTURED]  = captured;
    irq_st_d                        = irq_st_q;
    if (wr_clear) begin
      irq_st_d = irq_st_q & ~reg_wdata[`LSR_IRQ_W-1:0];
    end
    // A set in the same cycle as its clear wins
    irq_st_d = irq_st_d | irq_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  assign irq                = |(irq_st_q & irq_en_q);
  assign statusword_warning = irq_st_q[`LSR_IRQ_LIMIT_EVT];

  // Read data, one cycle after the read strobe
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_re) begin
      case (reg_addr)
        `LSR_OFF_REACTION:    rdata_d = {16'h0000, reaction_q};
        `LSR_OFF_HWINFO_CNT:  rdata_d = {24'h00_0000, `LSR_ENTRY_COUNT};
        `LSR_OFF_EEPROM_SIZE: rdata_d = EEPROM_SIZE_BYTES;
        `LSR_OFF_HWCFG_CNT:   rdata_d = {24'h00_0000, `LSR_ENTRY_COUNT};
        `LSR_OFF_HWCFG_WORD:  rdata_d = hwcfg_q;
        `LSR_OFF_IRQ_STATUS:  rdata_d = {{(32-`LSR_IRQ_W){1'b0}}, irq_st_q};
        `LSR_OFF_IRQ_ENABLE:  rdata_d = {{(32-`LSR_IRQ_W){1'b0}}, irq_en_q};
        `LSR_OFF_LIMIT_POS:   rdata_d = 32'(pos_q);
        `LSR_OFF_REACT_STATE: rdata_d = {29'h0000_0000, pos_valid_q, 2'(state_q)};
        default:              rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : lsr_top

// [dv/lsr_chk.sv]
// Port-level assertions for the limit switch reaction block.
// Assumes it is bound into lsr_top; one clock, reset async and active low.
`timescale 1ns/1ns
module lsr_chk #(
  parameter int POS_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_we,
  input wire logic ramp_done,
  input wire logic statusword_warning,
  input wire logic power_stage_off,
  input wire logic brake_slow,
  input wire logic brake_quick,
  input wire logic req_switch_on_disabled,
  input wire logic req_quick_stop_active,
  input wire logic limit_position_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_PWR_WITH_SOD: assert property (power_stage_off |-> req_switch_on_disabled && !brake_slow && !brake_quick)
    else $error("power off without switch-on-disabled request");
  AST_PWR_ONE: assert property (power_stage_off |=> !power_stage_off)
    else $error("power off pulse too long");
  AST_BRAKE_ONE: assert property (!(brake_slow && brake_quick))
    else $error("both ramps active");
  AST_BRAKE_HOLD: assert property ((brake_slow || brake_quick) && !ramp_done |=> $stable(brake_slow) && $stable(brake_quick))
    else $error("brake dropped before ramp end");
  AST_BRAKE_END: assert property ((brake_slow || brake_quick) && ramp_done |=> !(brake_slow || brake_quick) ##1 (req_switch_on_disabled || req_quick_stop_active))
    else $error("no state request after ramp end");
  AST_QSA_KEEP: assert property (req_quick_stop_active |-> !power_stage_off && !req_switch_on_disabled)
    else $error("quick stop active with power cut");
  AST_QSA_AFTER_BRAKE: assert property ($rose(req_quick_stop_active) |-> $past(brake_slow, 2) || $past(brake_quick, 2))
    else $error("quick stop active without braking");
  AST_WARN_STICKY: assert property (statusword_warning && !reg_we |=> statusword_warning)
    else $error("warning lost without a write");
  AST_WARN_WITH_REACT: assert property ($rose(brake_slow) || $rose(brake_quick) || power_stage_off |-> statusword_warning)
    else $error("reaction without warning");
  AST_CAPTURE_WARN: assert property ($rose(limit_position_valid) |-> statusword_warning)
    else $error("capture without warning");
endmodule : lsr_chk

bind lsr_top lsr_chk #(.POS_W(POS_W)) chk_u (.clk(clk), .rst_n(rst_n), .reg_we(reg_we), .ramp_done(ramp_done),
  .statusword_warning(statusword_warning), .power_stage_off(power_stage_off), .brake_slow(brake_slow),
  .brake_quick(brake_quick), .req_switch_on_disabled(req_switch_on_disabled),
  .req_quick_stop_active(req_quick_stop_active), .limit_position_valid(limit_position_valid));

// [dv/lsr_axis_mdl.sv]
// Axis model: limit switch levels, position and a braking ramp of set length.
// Assumes the bench commands hits, position and ramp length; shares clk.
`timescale 1ns/1ns
module lsr_axis_mdl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hit_pos,
  input  wire logic        hit_neg,
  input  wire logic [31:0] pos_cmd,
  input  wire logic [7:0]  ramp_len,
  input  wire logic        brake_slow,
  input  wire logic        brake_quick,
  output logic             limit_pos_pin,
  output logic             limit_neg_pin,
  output logic [31:0]      actual_position,
  output logic             ramp_done
);
  logic [7:0] cnt_q, cnt_d;
  logic       done_d;
  assign limit_pos_pin = hit_pos;
  assign limit_neg_pin = hit_neg;
  assign actual_position = pos_cmd;
  // Ramp reports once, ramp_len cycles after braking starts
  always_comb begin
    cnt_d = (brake_slow || brake_quick) ? cnt_q + 8'h01 : 8'h00;
    done_d = (brake_slow || brake_quick) && (cnt_d == ramp_len);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      ramp_done <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ramp_done <= done_d;
    end
  end
endmodule : lsr_axis_mdl

// [dv/lsr_top_tb.sv]
// Self-checking bench: register access and every reaction code.
// Assumes lsr_top, lsr_axis_mdl and the bound checker.
`timescale 1ns/1ns
`include "lsr_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module lsr_top_tb;
  logic        clk, rst_n, reg_we, reg_re, hit_pos, hit_neg, pin_p, pin_n, ramp_done;
  logic        warn, pwr_off, br_s, br_q, req_sod, req_qsa, pos_vld, irq;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pos_cmd, act_pos, lim_pos;
  logic [7:0]  ramp_len;
  int          bad_count, cmp_count, cyc, n_pwr, n_sod, n_qsa, n_slow, n_quick;
  logic [15:0] codes [9] = '{16'hffff, 16'h0000, 16'h0001, 16'h0002, 16'h0005,
                             16'h0006, 16'hfffe, 16'h0003, 16'h0004};

  lsr_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .limit_pos_pin(pin_p), .limit_neg_pin(pin_n),
    .actual_position(act_pos), .ramp_done(ramp_done), .statusword_warning(warn), .power_stage_off(pwr_off),
    .brake_slow(br_s), .brake_quick(br_q), .req_switch_on_disabled(req_sod), .req_quick_stop_active(req_qsa),
    .limit_position(lim_pos), .limit_position_valid(pos_vld), .irq(irq));
  lsr_axis_mdl mdl_u (.clk(clk), .rst_n(rst_n), .hit_pos(hit_pos), .hit_neg(hit_neg), .pos_cmd(pos_cmd),
    .ramp_len(ramp_len), .brake_slow(br_s), .brake_quick(br_q), .limit_pos_pin(pin_p),
    .limit_neg_pin(pin_n), .actual_position(act_pos), .ramp_done(ramp_done));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done;
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cyc++;
    n_pwr += pwr_off;
    n_sod += req_sod;
    n_qsa += req_qsa;
    n_slow += br_s;
    n_quick += br_q;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rdc

  task automatic ev(input logic [15:0] code, input int k);
    logic [31:0] st;
    int          i;
    st = (code == 16'hfffe) ? 32'h0000_0001 : (code inside {0, 1, 2, 5, 6}) ? 32'h0000_0003 : 32'h0000_0005;
    wr(`LSR_OFF_REACTION, {16'h0000, code});
    n_pwr = 0;
    n_sod = 0;
    n_qsa = 0;
    n_slow = 0;
    n_quick = 0;
    @(posedge clk);
    pos_cmd <= 32'h0001_2300 + k;
    ramp_len <= 8'(1 + 3 * k);
    hit_pos <= !k[0];
    hit_neg <= k[0];
    i = 0;
    while (warn !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    `CHK(warn, 1'b1)
    repeat (40) @(posedge clk);
    #1 `CHK(n_pwr, int'(code == 16'h0000))
    `CHK(n_sod, int'(code inside {0, 1, 2}))
    `CHK(n_qsa, int'(code inside {5, 6}))
    `CHK(n_slow > 0, code inside {1, 5})
    `CHK(n_quick > 0, code inside {2, 6})
    `CHK(pos_vld, code != 16'hfffe)
    if (st[2]) `CHK(lim_pos, 32'h0001_2300 + k)
    rdc(`LSR_OFF_IRQ_STATUS, st);
    `CHK(irq, 1'b1)
    wr(`LSR_OFF_IRQ_ENABLE, 32'h0000_0000);
    #1 `CHK(irq, 1'b0)
    wr(`LSR_OFF_IRQ_ENABLE, 32'h0000_0007);
    wr(`LSR_OFF_IRQ_CLEAR, 32'h0000_0007);
    rdc(`LSR_OFF_IRQ_STATUS, 32'h0000_0000);
    `CHK(warn, 1'b0)
    @(posedge clk);
    hit_pos <= 1'b0;
    hit_neg <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : ev

  initial begin
    rst_n = 1'b0;
    {reg_we, reg_re, hit_pos, hit_neg} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h0000_0000;
    pos_cmd = 32'h0000_0000;
    ramp_len = 8'h01;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`LSR_OFF_REACTION, 32'h0000_ffff);
    @(posedge clk);
    #1 `CHK(reg_rdata, 32'h0000_0000)
    rdc(`LSR_OFF_HWINFO_CNT, 32'h0000_0001);
    rdc(`LSR_OFF_EEPROM_SIZE, 32'h0000_0000);
    rdc(`LSR_OFF_HWCFG_CNT, 32'h0000_0001);
    rdc(`LSR_OFF_HWCFG_WORD, 32'h0000_0000);
    wr(`LSR_OFF_EEPROM_SIZE, 32'ha5a5_a5a5);
    rdc(`LSR_OFF_EEPROM_SIZE, 32'h0000_0000);
    wr(`LSR_OFF_HWCFG_CNT, 32'h0000_00ff);
    rdc(`LSR_OFF_HWCFG_CNT, 32'h0000_0001);
    wr(`LSR_OFF_HWCFG_WORD, 32'h1234_abcd);
    rdc(`LSR_OFF_HWCFG_WORD, 32'h1234_abcd);
    wr(`LSR_OFF_REACTION, 32'h5a5a_8001);
    rdc(`LSR_OFF_REACTION, 32'h0000_8001);
    rdc(16'h0000, 32'h0000_0000);
    wr(`LSR_OFF_IRQ_ENABLE, 32'h0000_0007);
    rdc(`LSR_OFF_IRQ_ENABLE, 32'h0000_0007);
    for (int k = 0; k < 9; k++) ev(codes[k], k);
    rdc(`LSR_OFF_LIMIT_POS, 32'h0001_2308);
    rdc(`LSR_OFF_REACT_STATE, 32'h0000_0004);
    rdc(`LSR_OFF_IRQ_CLEAR, 32'h0000_0000);
    test_done();
  end
endmodule : lsr_top_tb
